// ### eic_regs.svh
// Register offsets, field positions, reset values and timing counts of the interrupt enable slice.
`ifndef EIC_REGS_SVH
`define EIC_REGS_SVH

// ============================================================
// Register byte offsets
`define CTRL_A_OFF        12'h000
`define SYNC_BUSY_OFF     12'h004
`define LINE_SECURITY_SELECT_SEL_OFF    12'h008
`define IRQ_ENABLE_CLR_OFF 12'h00C
`define IRQ_ENABLE_SET_OFF 12'h010
`define IRQ_FLAG_OFF      12'h014
`define IRQ_MASK_OFF      12'h018

// ============================================================
// Field positions
`define CTRL_SOFT_RESET_BIT  0
`define CTRL_ENABLE_BIT      1
`define SYNC_SOFT_RESET_BIT  0
`define SYNC_ENABLE_BIT      1
`define NONSECURE_CHECK_BIT            31
`define LINE_MSB             7
`define STAT_SYNC_DONE_BIT   8

// ============================================================
// Reset values and timing
`define REG_RESET            32'h0000_0000
`define LINES_RESET          8'h00
`define SYNC_TIME_NS         20
`define CLK_PERIOD_NS        5
`define SYNC_CYCLES          ((`SYNC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_CNT_ONE         3'h1
`define SYNC_CNT_ZERO        3'h0
`define AXI_OKAY             2'h0
`define AXI_SLVERR           2'h2

`endif

// ### eic_pkg.sv
// Types shared by the interrupt enable slice.
package eic_pkg;

    // ============================================================
    // Sync engine states.
    typedef enum logic [1:0] {
        SYNC_IDLE,
        SYNC_RUN
    } sync_state_e;

    // Enable state seen by both set and clear views.
    typedef struct packed {
        logic       nonsecure_check;
        logic [7:0] external_line_enable;
    } enable_s;

    // Write request as decoded on the bus side.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
        logic        line_security_select;
    } wr_req_s;

endpackage : eic_pkg

// ### eic_enable_sync.sv
// AXI4-Lite register slice with sync busy status, enable set/clear, security gating and interrupt.
`timescale 1ns/1ps
`include "eic_regs.svh"

// How it works
// - The enable busy bit reads 1 from a secure enable write until its synchronisation ends, then 0.
// - The soft reset busy bit reads 1 from a secure soft reset write until its synchronisation ends.
// - Writing 1 to bit 31 of the enable-set register sets the check enable; 0 leaves it alone.
// - Writing 1 to bit x of the line field sets that line's enable; a bit reading 0 is off.
// - Writing 0 to a line bit of the enable-set register changes nothing.
// - Set and clear registers share one enable state and read back the same value.
// - A line's request reaches the interrupt output only while its enable bit is 1.
// - Non-secure access to a line's enable works only when its security select bit is 1.
module eic_enable_sync (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  line_req,
    input  wire logic        nonsecure_check_req,
    output logic [7:0]       line_irq,
    output logic             irq,
    output logic             enabled
);

    // ============================================================
    // Storage.
    eic_pkg::enable_s     en_r;
    logic [7:0]           line_security_select_r;
    logic                 ctrl_enable_r;
    logic                 aw_hold_r;
    logic                 w_hold_r;
    logic [11:0]          awaddr_r;
    logic                 awnonsec_r;
    logic [31:0]          wdata_r;
    logic [3:0]           wstrb_r;
    logic                 bvalid_r;
    logic [1:0]           bresp_r;
    logic                 rvalid_r;
    logic [31:0]          rdata_r;
    logic [1:0]           rresp_r;
    logic [1:0]           flag_r;
    logic [1:0]           mask_r;
    eic_pkg::sync_state_e sync_state_r;
    logic [2:0]           sync_cnt_r;
    logic                 busy_enable_r;
    logic                 busy_soft_reset_bit_r;
    logic [7:0]           line_irq_r;
    logic                 enable_hold_r;

    eic_pkg::wr_req_s     wr;
    logic                 wr_fire;
    logic [7:0]           access_mask;
    logic                 start_en;
    logic                 start_rst;
    logic                 sync_done;

    // Lines that the current write may touch, given its security.
    function automatic logic [7:0] line_gate(input logic line_security_select, input logic [7:0] sel);
        line_gate = line_security_select ? sel : 8'hFF;
    endfunction : line_gate

    // Checks that a write's low byte lane is enabled.
    function automatic logic lane0(input logic [3:0] strb);
        lane0 = strb[0];
    endfunction : lane0

    // ============================================================
    // Write channel: address and data taken in either order, response after both.
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign wr_fire       = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr.addr       = awaddr_r;
    assign wr.data       = wdata_r;
    assign wr.strb       = wstrb_r;
    assign wr.line_security_select     = awnonsec_r;
    assign access_mask   = line_gate(wr.line_security_select, line_security_select_r);

    // Captures address and data beats.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            aw_hold_r  <= 1'b0;
            w_hold_r   <= 1'b0;
            awaddr_r   <= 12'h000;
            awnonsec_r <= 1'b0;
            wdata_r    <= `REG_RESET;
            wstrb_r    <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r  <= 1'b1;
                awaddr_r   <= s_axi_awaddr;
                awnonsec_r <= s_axi_awprot[1];
            end else if (wr_fire) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `AXI_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            case (wr.addr)
                `CTRL_A_OFF, `SYNC_BUSY_OFF, `LINE_SECURITY_SELECT_SEL_OFF, `IRQ_ENABLE_CLR_OFF,
                `IRQ_ENABLE_SET_OFF, `IRQ_FLAG_OFF, `IRQ_MASK_OFF: bresp_r <= `AXI_OKAY;
                default: bresp_r <= `AXI_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ============================================================
    // Shared enable state: set view ORs in, clear view masks out.
    always_ff @(posedge core_clk) begin
        if (!rstn || (sync_done && busy_soft_reset_bit_r)) begin
            en_r <= '0;
        end else if (wr_fire && wr.addr == `IRQ_ENABLE_SET_OFF) begin
            if (lane0(wr.strb)) begin
                en_r.external_line_enable <= en_r.external_line_enable
                    | (wr.data[`LINE_MSB:0] & access_mask);
            end
            if (wr.strb[3] && wr.data[`NONSECURE_CHECK_BIT]) begin
                en_r.nonsecure_check <= 1'b1;
            end
        end else if (wr_fire && wr.addr == `IRQ_ENABLE_CLR_OFF) begin
            if (lane0(wr.strb)) begin
                en_r.external_line_enable <= en_r.external_line_enable
                    & ~(wr.data[`LINE_MSB:0] & access_mask);
            end
            if (wr.strb[3] && wr.data[`NONSECURE_CHECK_BIT]) begin
                en_r.nonsecure_check <= 1'b0;
            end
        end
    end

    // Security select and interrupt mask, written by secure software only.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            line_security_select_r <= `LINES_RESET;
            mask_r                 <= 2'h0;
        end else if (wr_fire && !wr.line_security_select && lane0(wr.strb)) begin
            if (wr.addr == `LINE_SECURITY_SELECT_SEL_OFF) begin
                line_security_select_r <= wr.data[`LINE_MSB:0];
            end
            if (wr.addr == `IRQ_MASK_OFF) begin
                mask_r <= wr.data[1:0];
            end
        end
    end

    // ============================================================
    // Secure control writes start a synchronisation of fixed length.
    assign start_en  = wr_fire && wr.addr == `CTRL_A_OFF && lane0(wr.strb) && !wr.line_security_select
                       && sync_state_r == eic_pkg::SYNC_IDLE;
    assign start_rst = start_en && wr.data[`CTRL_SOFT_RESET_BIT];
    assign sync_done = sync_state_r == eic_pkg::SYNC_RUN && sync_cnt_r == `SYNC_CNT_ONE;

    // Sync engine and busy bits.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sync_state_r  <= eic_pkg::SYNC_IDLE;
            sync_cnt_r    <= `SYNC_CNT_ZERO;
            busy_enable_r <= 1'b0;
            busy_soft_reset_bit_r  <= 1'b0;
            ctrl_enable_r <= 1'b0;
        end else begin
            case (sync_state_r)
                eic_pkg::SYNC_IDLE: begin
                    if (start_en) begin
                        sync_state_r  <= eic_pkg::SYNC_RUN;
                        sync_cnt_r    <= 3'(`SYNC_CYCLES);
                        busy_enable_r <= !start_rst;
                        busy_soft_reset_bit_r  <= start_rst;
                    end
                end
                eic_pkg::SYNC_RUN: begin
                    sync_cnt_r <= sync_cnt_r - `SYNC_CNT_ONE;
                    if (sync_done) begin
                        sync_state_r  <= eic_pkg::SYNC_IDLE;
                        busy_enable_r <= 1'b0;
                        busy_soft_reset_bit_r  <= 1'b0;
                        ctrl_enable_r <= busy_soft_reset_bit_r ? 1'b0 : enable_hold_r;
                    end
                end
                default: sync_state_r <= eic_pkg::SYNC_IDLE;
            endcase
        end
    end

    // Value of the enable bit being synchronised, applied when the sync ends.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            enable_hold_r <= 1'b0;
        end else if (start_en) begin
            enable_hold_r <= wr.data[`CTRL_ENABLE_BIT];
        end
    end
    assign enabled = ctrl_enable_r;

    // ============================================================
    // Line gating and status flags.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            line_irq_r <= `LINES_RESET;
        end else begin
            line_irq_r <= line_req & en_r.external_line_enable & {8{ctrl_enable_r}};
        end
    end
    assign line_irq = line_irq_r;

    // Flag 0: any gated line request or check event; flag 1: sync done. Set wins over clear.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            flag_r <= 2'h0;
        end else begin
            flag_r <= (flag_r & ~((wr_fire && wr.addr == `IRQ_FLAG_OFF && lane0(wr.strb))
                                  ? wr.data[1:0] : 2'h0))
                      | {sync_done, (|line_irq_r) | (nonsecure_check_req && en_r.nonsecure_check)};
        end
    end
    assign irq = |(flag_r & mask_r);

    // ============================================================
    // Read channel.
    assign s_axi_arready = !rvalid_r;

    // Read data; blocked lines read as zero for non-secure access.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= `REG_RESET;
            rresp_r  <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r  <= `AXI_OKAY;
            case (s_axi_araddr)
                `CTRL_A_OFF:     rdata_r <= {30'h0, ctrl_enable_r, 1'b0};
                `SYNC_BUSY_OFF:  rdata_r <= {30'h0, busy_enable_r, busy_soft_reset_bit_r};
                `LINE_SECURITY_SELECT_SEL_OFF: rdata_r <= {24'h0, line_security_select_r};
                `IRQ_ENABLE_SET_OFF, `IRQ_ENABLE_CLR_OFF:
                    rdata_r <= {en_r.nonsecure_check, 23'h0, en_r.external_line_enable
                                & line_gate(s_axi_arprot[1], line_security_select_r)};
                `IRQ_FLAG_OFF:   rdata_r <= {30'h0, flag_r};
                `IRQ_MASK_OFF:   rdata_r <= {30'h0, mask_r};
                default: begin
                    rdata_r <= `REG_RESET;
                    rresp_r <= `AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // ============================================================
    // Checks.
    busy_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_en && !start_rst |=> busy_enable_r [*4] ##1 !busy_enable_r)
        else $error("enable busy did not last the sync time");
    soft_reset_bit_busy_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_rst |=> busy_soft_reset_bit_r ##3 busy_soft_reset_bit_r ##1 !busy_soft_reset_bit_r)
        else $error("soft reset busy wrong length");
    nonsecure_check_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_fire && wr.addr == `IRQ_ENABLE_SET_OFF && wr.strb[3] && wr.data[`NONSECURE_CHECK_BIT]
        && !(sync_done && busy_soft_reset_bit_r) |=> en_r.nonsecure_check)
        else $error("check enable not set");
    line_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_fire && wr.addr == `IRQ_ENABLE_SET_OFF && lane0(wr.strb) && !wr.line_security_select
        && !(sync_done && busy_soft_reset_bit_r)
        |=> (en_r.external_line_enable & $past(wr.data[`LINE_MSB:0]))
            == $past(wr.data[`LINE_MSB:0]))
        else $error("line enable not set");
    zero_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_fire && wr.addr == `IRQ_ENABLE_SET_OFF && !(sync_done && busy_soft_reset_bit_r)
        |=> ($past(en_r.external_line_enable) & ~en_r.external_line_enable) == 8'h00)
        else $error("set write cleared a line");
    gate_line_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ##1 (line_irq_r & ~$past(en_r.external_line_enable)) == 8'h00)
        else $error("disabled line raised a request");
    secure_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_fire && wr.line_security_select && !(sync_done && busy_soft_reset_bit_r)
        |=> ((en_r.external_line_enable ^ $past(en_r.external_line_enable))
             & ~$past(line_security_select_r)) == 8'h00)
        else $error("secure line changed by non-secure write");
    shared_state_a: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_fire && wr.addr == `IRQ_ENABLE_CLR_OFF && lane0(wr.strb) && !wr.line_security_select
        && !(sync_done && busy_soft_reset_bit_r)
        |=> (en_r.external_line_enable & $past(wr.data[`LINE_MSB:0])) == 8'h00)
        else $error("clear view did not clear shared state");
    soft_reset_bit_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
        sync_done && busy_soft_reset_bit_r |=> en_r == '0)
        else $error("soft reset left enables set");
    sync_run_c: cover property (@(posedge core_clk) disable iff (!rstn) start_en ##4 sync_done);
    line_security_select_c: cover property (@(posedge core_clk) disable iff (!rstn) wr_fire && wr.line_security_select);
    irq_c: cover property (@(posedge core_clk) disable iff (!rstn) $rose(irq));

endmodule : eic_enable_sync

// ### ext_irq_enable_sync_security_tb.sv
// Self-checking testbench for the interrupt enable slice with its AXI4-Lite register bus.
`timescale 1ns/1ps
`include "eic_regs.svh"

module ext_irq_enable_sync_security_tb;

    // ============================================================
    // Signals
    logic        core_clk;
    logic        rstn;
    logic [11:0] awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic        awvalid, wvalid, arvalid, bready, rready;
    logic        awready, wready, arready, bvalid, rvalid;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  line_req, line_irq;
    logic        nonsecure_check_req, irq, enabled;
    logic [31:0] rd_val;
    logic [7:0]  line_irq_s;
    logic        irq_s;
    int          error_cnt, n_compared, cyc;

    eic_enable_sync eic_enable_sync_i (
        .core_clk(core_clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .line_req(line_req),
        .nonsecure_check_req(nonsecure_check_req), .line_irq(line_irq),
        .irq(irq), .enabled(enabled)
    );

    // ============================================================
    // Clock and cycle ceiling; a hang counts as a mismatch.
    always #2.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ============================================================
    // Tasks
    // Compares a seen value with the expected one and counts the result.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Writes one word; ready handshakes are waited for, the response is returned.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic ns);
        awaddr  <= a;
        awprot  <= {1'b0, ns, 1'b0};
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                break;
            end
        end
    endtask : axi_wr

    // Reads one word into rd_val and its response into resp.
    task automatic axi_rd(input logic [11:0] a, input logic ns);
        araddr  <= a;
        arprot  <= {1'b0, ns, 1'b0};
        arvalid <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd_val = rdata;
                resp   = rresp;
                break;
            end
        end
    endtask : axi_rd

    // Samples the interrupt outputs once settled, then returns on a rising edge.
    task automatic settle();
        @(posedge core_clk);
        #1;
        irq_s      = irq;
        line_irq_s = line_irq;
        @(posedge core_clk);
    endtask : settle

    // Prints the counts and the verdict, then ends the run.
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // ============================================================
    // Main sequence.
    initial begin
        core_clk = 1'b0; rstn = 1'b0; cyc = 0; error_cnt = 0; n_compared = 0;
        awaddr = 12'h000; araddr = 12'h000; awprot = 3'h0; arprot = 3'h0;
        awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; bready = 1'b1; rready = 1'b1;
        wdata = 32'h0; wstrb = 4'h0; line_req = 8'h00; nonsecure_check_req = 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        // Reset state of busy status, enables and interrupt.
        axi_rd(`SYNC_BUSY_OFF, 1'b0); chk(rd_val, 32'h0);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Set-only writes to the line field and the check bit.
        axi_wr(`IRQ_ENABLE_SET_OFF, 32'h0000_00A5, 1'b0); chk({30'h0, resp}, 32'h0);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h0000_00A5);
        axi_rd(`IRQ_ENABLE_CLR_OFF, 1'b0); chk(rd_val, 32'h0000_00A5);
        axi_wr(`IRQ_ENABLE_SET_OFF, 32'h0000_0000, 1'b0);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h0000_00A5);
        axi_wr(`IRQ_ENABLE_SET_OFF, 32'h8000_0000, 1'b0);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h8000_00A5);
        axi_wr(`IRQ_ENABLE_SET_OFF, 32'h0000_0040, 1'b0);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h8000_00E5);
        // Clearing through the clear view shows in the set view.
        axi_wr(`IRQ_ENABLE_CLR_OFF, 32'h0000_00C0, 1'b0);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h8000_0025);
        // Lines 3:0 non-secure, 7:4 secure; non-secure access sees only the former.
        axi_wr(`LINE_SECURITY_SELECT_SEL_OFF, 32'h0000_000F, 1'b0);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b1); chk(rd_val, 32'h8000_0005);
        axi_wr(`IRQ_ENABLE_SET_OFF, 32'h0000_00FF, 1'b1);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h8000_002F);
        axi_wr(`IRQ_ENABLE_CLR_OFF, 32'h0000_00FF, 1'b1);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h8000_0020);
        // An unmapped address answers with an error and zero data.
        axi_rd(12'h100, 1'b0); chk({30'h0, resp}, 32'h2); chk(rd_val, 32'h0);
        // Enable write: busy while synchronising, clear afterwards.
        axi_wr(`CTRL_A_OFF, 32'h0000_0002, 1'b0);
        axi_rd(`SYNC_BUSY_OFF, 1'b0); chk(rd_val, 32'h0000_0002);
        repeat (10) @(posedge core_clk);
        axi_rd(`SYNC_BUSY_OFF, 1'b0); chk(rd_val, 32'h0);
        chk({31'h0, enabled}, 32'h1);
        // Sync-done flag held while masked, then raised, then cleared.
        axi_rd(`IRQ_FLAG_OFF, 1'b0); chk(rd_val, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0);
        axi_wr(`IRQ_MASK_OFF, 32'h0000_0002, 1'b0);
        settle(); chk({31'h0, irq_s}, 32'h1);
        axi_wr(`IRQ_FLAG_OFF, 32'h0000_0002, 1'b0);
        settle(); chk({31'h0, irq_s}, 32'h0);
        axi_rd(`IRQ_FLAG_OFF, 1'b0); chk(rd_val, 32'h0);
        // Line requests pass only where the line is enabled.
        axi_wr(`IRQ_ENABLE_SET_OFF, 32'h0000_0003, 1'b0);
        line_req <= 8'hFF;
        repeat (3) settle();
        chk({24'h0, line_irq_s}, 32'h0000_0023);
        line_req <= 8'h00;
        repeat (3) settle();
        chk({24'h0, line_irq_s}, 32'h0);
        axi_rd(`IRQ_FLAG_OFF, 1'b0); chk(rd_val, 32'h0000_0001);
        // An enabled check event raises the event flag again after it is cleared.
        axi_wr(`IRQ_FLAG_OFF, 32'h0000_0001, 1'b0);
        axi_rd(`IRQ_FLAG_OFF, 1'b0); chk(rd_val, 32'h0);
        nonsecure_check_req <= 1'b1;
        settle();
        nonsecure_check_req <= 1'b0;
        axi_rd(`IRQ_FLAG_OFF, 1'b0); chk(rd_val, 32'h0000_0001);
        // Soft reset: busy while synchronising, enables cleared at its end.
        axi_wr(`CTRL_A_OFF, 32'h0000_0001, 1'b0);
        axi_rd(`SYNC_BUSY_OFF, 1'b0); chk(rd_val & 32'h1, 32'h1);
        repeat (10) @(posedge core_clk);
        axi_rd(`SYNC_BUSY_OFF, 1'b0); chk(rd_val, 32'h0);
        axi_rd(`IRQ_ENABLE_SET_OFF, 1'b0); chk(rd_val, 32'h0);
        end_of_test();
    end

endmodule : ext_irq_enable_sync_security_tb
